// *** design/bscan_pkg.sv ***
// Shared constants and types for the boundary-scan test port
package bscan_pkg;

  // ------------------------------------------------------------------
  // Register lengths
  // ------------------------------------------------------------------
  localparam int IR_LEN       = 10;   // Instruction register length
  localparam int BSR_LEN      = 960;  // Boundary register cells
  localparam int CELLS_PER_IO = 3;    // Input, output and enable cell per pin
  localparam int SIG_LEN      = 32;   // User signature length
  localparam int SIG_USER_LEN = 7;    // Bits chosen at configuration
  localparam int SIG_FIX_LEN  = 25;   // Bits fixed by the device
  localparam int ID_LEN       = 32;   // Identification register length
  localparam int CFG_LEN      = 32;   // Configuration word length
  localparam int SYNC_STAGES  = 3;    // Flops on an input from another domain

  // ------------------------------------------------------------------
  // Instruction codes
  // ------------------------------------------------------------------
  localparam logic [IR_LEN-1:0] INS_EXTEST   = 10'h000;
  localparam logic [IR_LEN-1:0] INS_SAMPLE   = 10'h055;
  localparam logic [IR_LEN-1:0] INS_USERCODE = 10'h007;
  localparam logic [IR_LEN-1:0] INS_IDCODE   = 10'h006;
  localparam logic [IR_LEN-1:0] INS_CFG_LOAD = 10'h002;
  localparam logic [IR_LEN-1:0] INS_BYPASS   = 10'h3ff;

  // ------------------------------------------------------------------
  // Reset and capture values
  // ------------------------------------------------------------------
  localparam logic [IR_LEN-1:0]      IR_CAPTURE   = 10'h001; // Low bits 01 on capture
  localparam logic [IR_LEN-1:0]      IR_RESET     = INS_IDCODE;
  localparam logic [SIG_FIX_LEN-1:0] SIG_FIXED    = 25'h0000001; // Arbitrary value
  localparam logic [ID_LEN-1:0]      ID_VALUE     = 32'h00000001; // Arbitrary value

  // ------------------------------------------------------------------
  // Test access controller states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } bscan_state_t;

endpackage

// *** design/bscan_xfer_if.sv ***
// Carrier for configuration words from the test clock side to the core side
`timescale 1ns/1ns
interface bscan_xfer_if;
  logic [31:0] word;    // Word held stable by the test side
  logic        toggle;  // Flips once per new word

  modport tx (output word, output toggle);
  modport rx (input word, input toggle);
endinterface

// *** design/bscan_cfg_rx.sv ***
// Core-clock receiver for configuration words streamed over the test port
`timescale 1ns/1ns
module bscan_cfg_rx (
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Crossing from the test clock side
  bscan_xfer_if.rx         xfer,
  // Word to the configuration logic
  output logic [31:0]      cfg_word,
  output logic             cfg_valid
);
  import bscan_pkg::*;

  logic [SYNC_STAGES-1:0] tog_sync_r;  // Toggle synchroniser chain
  logic                   tog_seen_r;  // Last toggle level acted on
  logic                   tog_new;     // Stages two and three agree on a change

  // ------------------------------------------------------------------
  // Toggle synchroniser
  // ------------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_sync_r <= '0;
    end else begin
      tog_sync_r <= {tog_sync_r[SYNC_STAGES-2:0], xfer.toggle};
    end
  end

  // Change counts once the two later stages agree
  assign tog_new = (tog_sync_r[1] == tog_sync_r[2]) && (tog_sync_r[2] != tog_seen_r);

  // ------------------------------------------------------------------
  // Word capture
  // ------------------------------------------------------------------
  // Word is stable by the time the toggle is seen, so it is sampled directly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_seen_r <= 1'b0;
      cfg_word   <= '0;
      cfg_valid  <= 1'b0;
    end else begin
      cfg_valid <= tog_new;
      if (tog_new) begin
        tog_seen_r <= tog_sync_r[2];
        cfg_word   <= xfer.word;
      end
    end
  end

endmodule

// *** design/bscan_tap.sv ***
// Boundary-scan test access port with boundary, signature and configuration registers
`timescale 1ns/1ns

// Function
// - Sample captures pins, preloads pattern, normal operation
// - Extest drives outputs from cells, captures inputs
// - Bypass inserts one-bit register, one stage delay
// - Usercode shifts out 32-bit user signature
// - Idcode shifts out identification register
// - Instruction register is ten bits long
// - Signature: seven user bits, twenty-five fixed
// - Boundary register holds 960 cells
// - Configuration instruction streams words into device
module bscan_tap #(
  parameter int N_IO = bscan_pkg::BSR_LEN / bscan_pkg::CELLS_PER_IO  // Pins under scan
) (
  // Core clock and reset
  input  wire logic                              CORE_CLK,
  input  wire logic                              ARST_N,
  // Serial test link
  input  wire logic                              TCK,
  input  wire logic                              TMS,
  input  wire logic                              TDI,
  output logic                                   TDO,
  output logic                                   TDO_OE,
  // Core side of the pins
  input  wire logic [N_IO-1:0]                   CORE_OUT,
  input  wire logic [N_IO-1:0]                   CORE_OE,
  // Device pins
  input  wire logic [N_IO-1:0]                   PIN_IN,
  output logic      [N_IO-1:0]                   PIN_OUT,
  output logic      [N_IO-1:0]                   PIN_OE,
  // Configuration
  input  wire logic [bscan_pkg::SIG_USER_LEN-1:0] USER_SIG,
  output logic      [bscan_pkg::CFG_LEN-1:0]      CFG_WORD,
  output logic                                    CFG_VALID
);
  import bscan_pkg::*;

  localparam int NB = N_IO * CELLS_PER_IO;  // Boundary length

  bscan_state_t      state_r;                  // Controller state
  bscan_state_t      state_nxt;                // Next controller state
  logic [IR_LEN-1:0] ir_sh_r;                  // Instruction shift stage
  logic [IR_LEN-1:0] ir_r;                     // Active instruction
  logic              byp_r;                    // Bypass bit
  logic [SIG_LEN-1:0] sig_sh_r;                // Signature shift stage
  logic [ID_LEN-1:0]  id_sh_r;                 // Identification shift stage
  logic [CFG_LEN-1:0] cfg_sh_r;                // Configuration shift stage
  logic [CFG_LEN-1:0] cfg_hold_r;              // Word offered to the core
  logic               cfg_tog_r;               // Toggle per offered word
  logic [NB-1:0]      bsr_sh_r;                // Boundary shift stage
  logic [NB-1:0]      bsr_upd_r;               // Boundary update latches
  logic [3*N_IO-1:0]  pin_s1_r;                // Pin and core drive stage 1
  logic [3*N_IO-1:0]  pin_s2_r;                // Pin and core drive stage 2
  logic [3*N_IO-1:0]  pin_s3_r;                // Pin and core drive stage 3
  logic [3*N_IO-1:0]  pin_q_r;                 // Settled {enable, drive, pin}
  logic [SIG_USER_LEN-1:0] usr_s1_r;           // User bits stage 1
  logic [SIG_USER_LEN-1:0] usr_s2_r;           // User bits stage 2
  logic [SIG_USER_LEN-1:0] usr_s3_r;           // User bits stage 3
  logic [SIG_USER_LEN-1:0] usr_q_r;            // Settled user bits
  logic               extest;                  // Pins under test control
  logic               tdo_nxt;                 // Serial output before retiming

  bscan_xfer_if xfer ();                       // Crossing to the core side

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Next controller state from state and mode select
  function automatic bscan_state_t tap_next(input bscan_state_t s, input logic m);
    case (s)
      ST_RESET:  tap_next = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  tap_next = m ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  tap_next = m ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
      default:   tap_next = m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction

  // Boundary instructions share capture, shift and update
  function automatic logic is_bsr(input logic [IR_LEN-1:0] ins);
    is_bsr = (ins == INS_SAMPLE) || (ins == INS_EXTEST);
  endfunction

  // ------------------------------------------------------------------
  // Controller
  // ------------------------------------------------------------------
  assign state_nxt = tap_next(state_r, TMS);

  // Five high mode-select clocks always reach reset
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------------
  // Instruction changes only in the update and reset states
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ir_sh_r <= '0;
      ir_r    <= IR_RESET;
    end else begin
      case (state_r)
        ST_RESET:  ir_r    <= IR_RESET;
        ST_CAP_IR: ir_sh_r <= IR_CAPTURE;
        ST_SH_IR:  ir_sh_r <= {TDI, ir_sh_r[IR_LEN-1:1]};
        ST_UPD_IR: ir_r    <= ir_sh_r;
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  // Pins, core drive and user bits are foreign to the test clock; a bit moves on only
  // when the later stages agree, so a glitch never reaches a capture
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_q_r  <= '0;
      usr_s1_r <= '0;
      usr_s2_r <= '0;
      usr_s3_r <= '0;
      usr_q_r  <= '0;
    end else begin
      pin_s1_r <= {CORE_OE, CORE_OUT, PIN_IN};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_q_r  <= (pin_q_r & (pin_s2_r ^ pin_s3_r)) | (pin_s3_r & ~(pin_s2_r ^ pin_s3_r));
      usr_s1_r <= USER_SIG;
      usr_s2_r <= usr_s1_r;
      usr_s3_r <= usr_s2_r;
      usr_q_r  <= (usr_q_r & (usr_s2_r ^ usr_s3_r)) | (usr_s3_r & ~(usr_s2_r ^ usr_s3_r));
    end
  end

  // ------------------------------------------------------------------
  // Boundary register
  // ------------------------------------------------------------------
  // Capture takes pin inputs and core drive; the update latches keep the
  // preloaded pattern until an external test puts it on the pins
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      bsr_sh_r  <= '0;
      bsr_upd_r <= '0;
    end else if (is_bsr(ir_r)) begin
      if (state_r == ST_CAP_DR) begin
        for (int i = 0; i < N_IO; i++) begin
          bsr_sh_r[CELLS_PER_IO*i]   <= pin_q_r[i];
          bsr_sh_r[CELLS_PER_IO*i+1] <= pin_q_r[N_IO+i];
          bsr_sh_r[CELLS_PER_IO*i+2] <= pin_q_r[2*N_IO+i];
        end
      end else if (state_r == ST_SH_DR) begin
        bsr_sh_r <= {TDI, bsr_sh_r[NB-1:1]};
      end else if (state_r == ST_UPD_DR) begin
        bsr_upd_r <= bsr_sh_r;
      end
    end
  end

  // Pins follow the core except under external test
  assign extest = (ir_r == INS_EXTEST);

  // Output and enable cells drive the pins under external test
  always_comb begin
    for (int i = 0; i < N_IO; i++) begin
      PIN_OUT[i] = extest ? bsr_upd_r[CELLS_PER_IO*i+1] : CORE_OUT[i];
      PIN_OE[i]  = extest ? bsr_upd_r[CELLS_PER_IO*i+2] : CORE_OE[i];
    end
  end

  // ------------------------------------------------------------------
  // Bypass, signature and identification registers
  // ------------------------------------------------------------------
  // Bypass captures zero, then delays the serial input one stage
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      byp_r <= 1'b0;
    end else if (state_r == ST_CAP_DR) begin
      byp_r <= 1'b0;
    end else if (state_r == ST_SH_DR) begin
      byp_r <= TDI;
    end
  end

  // Signature loads user bits above the fixed part on capture
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sig_sh_r <= '0;
      id_sh_r  <= '0;
    end else if (state_r == ST_CAP_DR) begin
      sig_sh_r <= {usr_q_r, SIG_FIXED};
      id_sh_r  <= ID_VALUE;
    end else if (state_r == ST_SH_DR) begin
      if (ir_r == INS_USERCODE) begin
        sig_sh_r <= {TDI, sig_sh_r[SIG_LEN-1:1]};
      end
      if (ir_r == INS_IDCODE) begin
        id_sh_r <= {TDI, id_sh_r[ID_LEN-1:1]};
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration stream
  // ------------------------------------------------------------------
  // Each update hands a whole word over; the held word stays stable until
  // the next update, which is at least four test clocks later
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_sh_r   <= '0;
      cfg_hold_r <= '0;
      cfg_tog_r  <= 1'b0;
    end else if (ir_r == INS_CFG_LOAD) begin
      if (state_r == ST_SH_DR) begin
        cfg_sh_r <= {TDI, cfg_sh_r[CFG_LEN-1:1]};
      end else if (state_r == ST_UPD_DR) begin
        cfg_hold_r <= cfg_sh_r;
        cfg_tog_r  <= ~cfg_tog_r;
      end
    end
  end

  assign xfer.word   = cfg_hold_r;
  assign xfer.toggle = cfg_tog_r;

  // Core-side receiver of streamed words
  bscan_cfg_rx u_cfg_rx (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .xfer      (xfer),
    .cfg_word  (CFG_WORD),
    .cfg_valid (CFG_VALID)
  );

  // ------------------------------------------------------------------
  // Serial output
  // ------------------------------------------------------------------
  // Selected register's low bit; unknown codes fall back to bypass
  always_comb begin
    if (state_r == ST_SH_IR) begin
      tdo_nxt = ir_sh_r[0];
    end else if (is_bsr(ir_r)) begin
      tdo_nxt = bsr_sh_r[0];
    end else if (ir_r == INS_USERCODE) begin
      tdo_nxt = sig_sh_r[0];
    end else if (ir_r == INS_IDCODE) begin
      tdo_nxt = id_sh_r[0];
    end else if (ir_r == INS_CFG_LOAD) begin
      tdo_nxt = cfg_sh_r[0];
    end else begin
      tdo_nxt = byp_r;
    end
  end

  // Retimed on the falling edge so the controller samples a settled bit
  always_ff @(negedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      TDO    <= tdo_nxt;
      TDO_OE <= (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
    end
  end

endmodule

// *** bench/bscan_tap_monitor.sv ***
// Concurrent checks on the ports of the boundary-scan test port
`timescale 1ns/1ns
module bscan_tap_monitor #(
  parameter int N_IO = 320  // Pins under scan
) (
  // Core clock and reset
  input wire logic                               CORE_CLK,
  input wire logic                               ARST_N,
  // Serial test link
  input wire logic                               TCK,
  input wire logic                               TMS,
  input wire logic                               TDI,
  input wire logic                               TDO,
  input wire logic                               TDO_OE,
  // Pins
  input wire logic [N_IO-1:0]                    CORE_OUT,
  input wire logic [N_IO-1:0]                    CORE_OE,
  input wire logic [N_IO-1:0]                    PIN_IN,
  input wire logic [N_IO-1:0]                    PIN_OUT,
  input wire logic [N_IO-1:0]                    PIN_OE,
  // Configuration
  input wire logic [bscan_pkg::SIG_USER_LEN-1:0] USER_SIG,
  input wire logic [bscan_pkg::CFG_LEN-1:0]      CFG_WORD,
  input wire logic                               CFG_VALID
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  // Five ones then a zero always lands in run-test/idle
  sequence s_rti; TMS [*5] ##1 !TMS; endsequence
  property p_pin_rst; @(posedge CORE_CLK) disable iff (!ARST_N) $rose(ARST_N) |-> PIN_OUT == CORE_OUT; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pins not on core after reset");
  property p_vgap; @(posedge CORE_CLK) disable iff (!ARST_N) CFG_VALID |=> !CFG_VALID [*8]; endproperty
  a_vgap: assert property (p_vgap) else $error("config valid not a lone pulse");
  property p_word; @(posedge CORE_CLK) disable iff (!ARST_N) $changed(CFG_WORD) |-> CFG_VALID; endproperty
  a_word: assert property (p_word) else $error("config word moved without valid");
  property p_dr_in; @(posedge TCK) disable iff (!ARST_N) s_rti ##1 TMS ##1 !TMS [*2] |=> TDO_OE; endproperty
  a_dr_in: assert property (p_dr_in) else $error("data shift not entered");
  property p_ir_in; @(posedge TCK) disable iff (!ARST_N) s_rti ##1 TMS [*2] ##1 !TMS [*2] |=> TDO_OE; endproperty
  a_ir_in: assert property (p_ir_in) else $error("instruction shift not entered");
  property p_oe_exit; @(posedge TCK) disable iff (!ARST_N) TDO_OE && TMS |=> !TDO_OE; endproperty
  a_oe_exit: assert property (p_oe_exit) else $error("output enable kept after exit");
  property p_oe_hold; @(posedge TCK) disable iff (!ARST_N) TDO_OE && !TMS |=> TDO_OE; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("output enable lost in shift");
  property p_oe_off; @(posedge TCK) disable iff (!ARST_N) TMS [*2] |-> !TDO_OE; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enable outside shift");
  // Main scenarios reached
  c_cfg: cover property (@(posedge CORE_CLK) CFG_VALID);
  c_exit: cover property (@(posedge TCK) TDO_OE && TMS);
  c_rti: cover property (@(posedge TCK) s_rti);
endmodule

// *** bench/bscan_ctl_model.sv ***
// Test controller model driving the serial test link
`timescale 1ns/1ns
module bscan_ctl_model (
  // Serial test link
  output logic         tck,
  output logic         tms,
  output logic         tdi,
  input  wire logic    tdo,
  // Scan result to the bench
  output logic [967:0] got,
  output logic         done
);
  // Link idles with clock low, as between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    got = '0;
    done = 1'b0;
  end

  // One link cycle; TDO taken at the rise, clock still afterwards
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62 tck = 1'b1;
    o = tdo;
    #63 tck = 1'b0;
  endtask

  // Five ones reach reset from anywhere, then idle
  task automatic tms_reset();
    logic o;
    repeat (5) tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask

  // Full scan from idle back to idle; TDI toggles where unused
  task automatic scan(input bit ir, input int n, input logic [967:0] din);
    logic o;
    got = '0;
    tick(1'b1, ~tdi, o);
    if (ir) begin
      tick(1'b1, ~tdi, o);
    end
    tick(1'b0, ~tdi, o);
    tick(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      got[i] = o;
    end
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
    done = 1'b1;
    #1 done = 1'b0;
  endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
module tb;
  import bscan_pkg::*;
  localparam int N_IO = BSR_LEN / CELLS_PER_IO;
  localparam int W = 968;  // Longest scan: register plus eight
  typedef struct { string nm; logic [W-1:0] exp; logic [W-1:0] msk; } bscan_note_t;
  logic core_clk, arst_n, tms, tdi, tck, tdo, tdo_oe, cfg_valid, done;
  logic [N_IO-1:0] core_out, core_oe, pin_in, pin_out, pin_oe;
  logic [SIG_USER_LEN-1:0] user_sig;
  logic [CFG_LEN-1:0] cfg_word, pw;
  logic [W-1:0] got, d, pmask, imask;
  logic [IR_LEN-1:0] bp [2] = '{INS_BYPASS, 10'h1a5};  // Unknown code acts as bypass
  bscan_note_t scan_q [$];
  bscan_note_t sn;
  logic [31:0] cfg_q [$];
  integer seed, fails = 0, compares = 0, cycles = 0;

  bscan_tap #(.N_IO(N_IO)) dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe), .CORE_OUT(core_out), .CORE_OE(core_oe), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .USER_SIG(user_sig), .CFG_WORD(cfg_word), .CFG_VALID(cfg_valid));
  bscan_ctl_model mdl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .got(got), .done(done));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input string nm, input logic [W-1:0] e, input logic [W-1:0] g, input logic [W-1:0] m);
    compares++;
    if (((e ^ g) & m) !== '0) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [W-1:0] rnd_vec();
    for (int k = 0; k < W / 8; k++) rnd_vec[k*8 +: 8] = $random(seed);
  endfunction
  // Cell o of each pin out of a register image
  function automatic logic [W-1:0] outs(input logic [W-1:0] v, input int o);
    outs = '0;
    for (int i = 0; i < N_IO; i++) outs[i] = v[3*i+o];
  endfunction
  // Capture image: input, output, enable cell per pin
  function automatic logic [W-1:0] cap();
    cap = '0;
    for (int i = 0; i < N_IO; i++) cap[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
  endfunction
  task automatic rnd_pins();
    @(posedge core_clk);
    for (int k = 0; k < N_IO / 32; k++) begin
      core_out[k*32 +: 32] <= $random(seed);
      core_oe[k*32 +: 32] <= $random(seed);
      pin_in[k*32 +: 32] <= $random(seed);
    end
    user_sig <= 7'($random(seed));
  endtask
  // Note the expected scan-out, then run the scan
  task automatic dr(input string nm, input int n, input logic [W-1:0] e, input logic [W-1:0] din,
                    input logic [W-1:0] m = '1, input bit ir = 1'b0);
    scan_q.push_back('{nm, e, m & ((W'(1) << n) - W'(1))});
    mdl.scan(ir, n, din);
  endtask
  task automatic ir(input logic [IR_LEN-1:0] code);
    dr("ir_capture", IR_LEN, W'(IR_CAPTURE), W'(code), '1, 1'b1);
  endtask

  // ------------------------------------------------------------------
  // Clock, watchers and timeout
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge done) begin
    sn = scan_q.pop_front();
    check(sn.nm, sn.exp, got, sn.msk);
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cfg_valid !== 1'b0 && arst_n === 1'b1) begin
      if (cfg_q.size() == 0) check("cfg_extra", '0, '1, '1);
      else check("cfg_word", W'(cfg_q.pop_front()), W'(cfg_word), W'(32'hffffffff));
    end
    if (cycles == 90000) begin
      fails++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 32'h4d6f46dd;
    arst_n = 1'b0;
    {core_out, core_oe, pin_in, user_sig} = '0;
    pmask = (W'(1) << N_IO) - W'(1);
    imask = outs('1, 0) << 0;
    imask = '0;
    for (int i = 0; i < N_IO; i++) imask[3*i] = 1'b1;
    imask[W-1 -: 8] = 8'hff;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    rnd_pins();
    mdl.tms_reset();
    dr("idcode_rst", ID_LEN, W'(ID_VALUE), rnd_vec());
    mdl.tms_reset();
    ir(INS_USERCODE);
    dr("usercode", SIG_LEN, W'({user_sig, SIG_FIXED}), rnd_vec());
    foreach (bp[i]) begin
      ir(bp[i]);
      d = rnd_vec();
      dr("bypass", 16, {d[W-2:0], 1'b0}, d);
    end
    ir(INS_IDCODE);
    dr("idcode", ID_LEN, W'(ID_VALUE), rnd_vec());
    ir(INS_SAMPLE);
    d = rnd_vec();
    dr("sample_cap", BSR_LEN, cap(), d);
    #1 check("sample_pins", W'(core_out), W'(pin_out), pmask);
    rnd_pins();
    ir(INS_EXTEST);
    #1 check("extest_out", outs(d, 1), W'(pin_out), pmask);
    check("extest_oe", outs(d, 2), W'(pin_oe), pmask);
    d = rnd_vec();
    dr("extest_cap", BSR_LEN + 8, cap() | (W'(d[7:0]) << BSR_LEN), d, imask);
    #1 check("extest_upd", outs(d >> 8, 1), W'(pin_out), pmask);
    ir(INS_CFG_LOAD);
    pw = '0;
    repeat (2) begin
      d = rnd_vec();
      cfg_q.push_back(d[31:0]);
      dr("cfg_shift", CFG_LEN, W'(pw), d);
      pw = d[31:0];
    end
    repeat (40) @(posedge core_clk);
    check("cfg_left", '0, W'(cfg_q.size()), '1);
    summarize();
  end
endmodule

bind bscan_tap bscan_tap_monitor #(.N_IO(N_IO)) u_mon (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .TCK(TCK),
  .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE), .CORE_OUT(CORE_OUT), .CORE_OE(CORE_OE), .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .USER_SIG(USER_SIG), .CFG_WORD(CFG_WORD), .CFG_VALID(CFG_VALID));
